// ---- ledsh_top.sv ----
// led panel shifter: registers, fifo, dma fetch and lane shifting
`timescale 1ns/10ps
module ledsh_top #(
    parameter int FIFO_DEPTH = 4
) (
    // clock, reset and enable
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      ce_i,
    // special function register port
    input  wire ledsh_pkg::ledsh_sfr_req_t sfr_i,
    output logic [7:0]                     sfr_rdata_o,
    // dma read port towards xram
    output ledsh_pkg::ledsh_dma_req_t      dma_o,
    input  wire ledsh_pkg::ledsh_dma_rsp_t dma_i,
    // panel pins
    output ledsh_pkg::ledsh_pins_t         pins_o
);

    if (FIFO_DEPTH < 4 || FIFO_DEPTH > 7) begin : g_depth_check
        $error("FIFO_DEPTH must lie between 4 and 7");
    end

    localparam logic [2:0] DEPTH = 3'(FIFO_DEPTH);

    typedef struct packed {
        logic [7:0]               ctrl;
        logic [7:0]               ck_div;
        logic [10:0]              mptr;
        logic [10:0]              xptr;
        logic [7:0]               wcnt;
        logic                     done;
        logic                     refill;
        logic [7:0][7:0]          fifo;
        logic [2:0]               frd;
        logic [2:0]               fcnt;
        ledsh_pkg::ledsh_dma_st_t dst;
        logic [15:0]              hold;
        logic                     busy;
        logic                     gap;
        logic [2:0]               sidx;
        logic [1:0]               smode;
        logic                     sorder;
        logic [7:0]               sa;
        logic [7:0]               sb;
        logic [3:0]               lanes;
        logic [7:0]               rdata;
    } ledsh_st_t;

    ledsh_st_t  s_q;
    ledsh_st_t  s_d;
    logic       tick;
    logic       sclk;
    logic [1:0] mode;
    logic       clr_all;
    logic       out_en;

    assign mode    = {s_q.ctrl[ledsh_pkg::CTRL_MODE_HI],
                      s_q.ctrl[ledsh_pkg::CTRL_MODE_LO]};
    assign clr_all = s_q.ctrl[ledsh_pkg::CTRL_CLR_ALL];
    assign out_en  = s_q.ctrl[ledsh_pkg::CTRL_OUT_EN];

    ledsh_clkdiv u_clkdiv (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .run_i    (out_en && !clr_all),
        .factor_i (s_q.ck_div),
        .tick_o   (tick),
        .sclk_o   (sclk)
    );

    function automatic logic [2:0] wrap(input logic [2:0] a,
                                        input logic [2:0] b);
        logic [3:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum >= {1'b0, DEPTH}) begin
            sum = sum - {1'b0, DEPTH};
        end
        return sum[2:0];
    endfunction : wrap

    function automatic logic pick(input logic [7:0] b,
                                  input logic [2:0] pos,
                                  input logic       msb_first);
        return msb_first ? b[3'h7 - pos] : b[pos];
    endfunction : pick

    // last step index of one load for each lane mode
    function automatic logic [2:0] last_step(input logic [1:0] m);
        case (m)
            ledsh_pkg::MODE_ONE:  return 3'h7;
            ledsh_pkg::MODE_FOUR: return 3'h1;
            default:              return 3'h3;
        endcase
    endfunction : last_step

    function automatic logic [3:0] lane_bits(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic [1:0] m,
                                             input logic [2:0] idx,
                                             input logic       msb);
        logic [3:0] l;
        l = 4'h0;
        case (m)
            ledsh_pkg::MODE_ONE: begin
                l[0] = pick(a, idx, msb);
            end
            ledsh_pkg::MODE_TWO: begin
                for (int k = 0; k < 2; k++) begin
                    l[k] = pick(a, 3'({idx[1:0], 1'b0}) + 3'(k), msb);
                end
            end
            ledsh_pkg::MODE_FOUR: begin
                for (int k = 0; k < 4; k++) begin
                    l[k] = pick(a, 3'({idx[0], 2'b00}) + 3'(k), msb);
                end
            end
            default: begin
                for (int k = 0; k < 2; k++) begin
                    l[k]     = pick(a, 3'({idx[1:0], 1'b0}) + 3'(k), msb);
                    l[k + 2] = pick(b, 3'({idx[1:0], 1'b0}) + 3'(k), msb);
                end
            end
        endcase
        return l;
    endfunction : lane_bits

    always_comb begin
        logic [7:0][7:0] push_b;
        logic [2:0]      n_push;
        logic [2:0]      n_pop;
        logic [2:0]      need;
        logic            clr_done;
        logic            clr_refill;
        logic            set_done;
        logic            sw_push;
        logic [2:0]      free;
        logic [2:0]      widx;

        s_d        = s_q;
        push_b     = '0;
        n_push     = 3'h0;
        n_pop      = 3'h0;
        clr_done   = 1'b0;
        clr_refill = 1'b0;
        set_done   = 1'b0;
        sw_push    = 1'b0;
        need       = (mode == ledsh_pkg::MODE_SPLIT) ? 3'h4 : 3'h2;
        free       = DEPTH - s_q.fcnt;
        widx       = 3'h0;

        // register writes
        if (sfr_i.wr) begin
            case (sfr_i.addr)
                ledsh_pkg::ADDR_CTRL:    s_d.ctrl   = sfr_i.wdata;
                ledsh_pkg::ADDR_CK_DIV:  s_d.ck_div = sfr_i.wdata;
                ledsh_pkg::ADDR_DATA:    sw_push    = 1'b1;
                ledsh_pkg::ADDR_MPTR_HI: begin
                    s_d.mptr[10:7] = sfr_i.wdata[3:0];
                end
                ledsh_pkg::ADDR_MPTR_LO: begin
                    s_d.mptr[6:0] = sfr_i.wdata[7:1];
                end
                ledsh_pkg::ADDR_XPTR_HI: begin
                    s_d.xptr[10:7] = sfr_i.wdata[3:0];
                end
                ledsh_pkg::ADDR_XPTR_LO: begin
                    s_d.xptr[6:0] = sfr_i.wdata[7:1];
                end
                ledsh_pkg::ADDR_WORD_CNT: begin
                    s_d.wcnt = sfr_i.wdata;
                    clr_done = 1'b1;
                end
                ledsh_pkg::ADDR_STAT: begin
                    clr_done   = sfr_i.wdata[ledsh_pkg::STAT_DMA_DONE];
                    clr_refill = sfr_i.wdata[ledsh_pkg::STAT_REFILL];
                end
                default: ;
            endcase
        end

        // lane shifter, one step per serial clock period
        if (tick) begin
            if (s_q.busy && s_q.sidx != last_step(s_q.smode)) begin
                s_d.sidx  = s_q.sidx + 3'h1;
                s_d.lanes = lane_bits(s_q.sa, s_q.sb, s_q.smode,
                                      s_d.sidx, s_q.sorder);
            end else if (s_q.fcnt >= ((mode == ledsh_pkg::MODE_SPLIT) ?
                                      3'h2 : 3'h1)) begin
                s_d.busy   = 1'b1;
                s_d.sidx   = 3'h0;
                s_d.smode  = mode;
                s_d.sorder = s_q.ctrl[ledsh_pkg::CTRL_BIT_ORDER];
                s_d.sa     = s_q.fifo[s_q.frd];
                s_d.sb     = s_q.fifo[wrap(s_q.frd, 3'h1)];
                n_pop      = (mode == ledsh_pkg::MODE_SPLIT) ? 3'h2 : 3'h1;
                s_d.lanes  = lane_bits(s_d.sa, s_d.sb, mode, 3'h0,
                                       s_d.sorder);
            end else begin
                s_d.busy  = 1'b0;
                s_d.lanes = 4'h0;
            end
        end
        if (!out_en) begin
            s_d.busy  = 1'b0;
            s_d.lanes = 4'h0;
        end

        // dma fetch sequencer
        s_d.gap = 1'b0;
        case (s_q.dst)
            ledsh_pkg::LEDSH_DMA_IDLE: begin
                if (s_q.ctrl[ledsh_pkg::CTRL_DMA_EN] && !clr_all &&
                    s_q.wcnt != 8'h00 && free >= need) begin
                    s_d.dst = ledsh_pkg::LEDSH_DMA_MAIN;
                end
            end
            ledsh_pkg::LEDSH_DMA_MAIN: begin
                if (dma_i.ack) begin
                    s_d.hold = dma_i.rdata;
                    s_d.mptr = s_q.mptr + 11'h001;
                    s_d.wcnt = s_q.wcnt - 8'h01;
                    set_done = (s_q.wcnt == 8'h01);
                    if (mode == ledsh_pkg::MODE_SPLIT) begin
                        s_d.dst = ledsh_pkg::LEDSH_DMA_AUX;
                        // request drops one cycle before the aux fetch
                        s_d.gap = 1'b1;
                    end else begin
                        push_b[0] = dma_i.rdata[7:0];
                        push_b[1] = dma_i.rdata[15:8];
                        n_push    = 3'h2;
                        s_d.dst   = ledsh_pkg::LEDSH_DMA_IDLE;
                    end
                end
            end
            ledsh_pkg::LEDSH_DMA_AUX: begin
                if (dma_i.ack && !s_q.gap) begin
                    // counter untouched by auxiliary fetches
                    s_d.xptr  = s_q.xptr + 11'h001;
                    push_b[0] = s_q.hold[7:0];
                    push_b[1] = dma_i.rdata[7:0];
                    push_b[2] = s_q.hold[15:8];
                    push_b[3] = dma_i.rdata[15:8];
                    n_push    = 3'h4;
                    s_d.dst   = ledsh_pkg::LEDSH_DMA_IDLE;
                end
            end
            default: s_d.dst = ledsh_pkg::LEDSH_DMA_IDLE;
        endcase

        // a software byte is taken only when dma pushes nothing and room
        if (sw_push && n_push == 3'h0 && s_q.fcnt != DEPTH) begin
            push_b[0] = sfr_i.wdata;
            n_push    = 3'h1;
        end

        // fifo update: pops first, then pushes behind the remaining bytes
        s_d.frd  = wrap(s_q.frd, n_pop);
        s_d.fcnt = s_q.fcnt - n_pop;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < n_push) begin
                widx = wrap(s_d.frd, s_d.fcnt);
                s_d.fifo[widx] = push_b[i];
                s_d.fcnt       = s_d.fcnt + 3'h1;
            end
        end

        // sticky flags: a set in the clearing cycle wins
        if (clr_done) begin
            s_d.done = 1'b0;
        end
        if (set_done) begin
            s_d.done = 1'b1;
        end
        if (clr_refill) begin
            s_d.refill = 1'b0;
        end
        if (s_d.fcnt <= ledsh_pkg::REFILL_LEVEL) begin
            s_d.refill = 1'b1;
        end

        // clear-all empties the fifo and flags; a fetch in flight finishes
        if (clr_all) begin
            s_d.fcnt   = 3'h0;
            s_d.frd    = 3'h0;
            s_d.done   = 1'b0;
            s_d.refill = 1'b0;
            s_d.busy   = 1'b0;
            s_d.lanes  = 4'h0;
        end

        // read data, answered one cycle after the strobe
        if (sfr_i.rd) begin
            case (sfr_i.addr)
                ledsh_pkg::ADDR_CTRL:     s_d.rdata = s_q.ctrl;
                ledsh_pkg::ADDR_CK_DIV:   s_d.rdata = s_q.ck_div;
                ledsh_pkg::ADDR_MPTR_HI:  s_d.rdata = {4'h0, s_q.mptr[10:7]};
                ledsh_pkg::ADDR_MPTR_LO:  s_d.rdata = {s_q.mptr[6:0], 1'b0};
                ledsh_pkg::ADDR_XPTR_HI:  s_d.rdata = {4'h0, s_q.xptr[10:7]};
                ledsh_pkg::ADDR_XPTR_LO:  s_d.rdata = {s_q.xptr[6:0], 1'b0};
                ledsh_pkg::ADDR_WORD_CNT: s_d.rdata = s_q.wcnt;
                ledsh_pkg::ADDR_FIFO_CN:  s_d.rdata = {5'h00, s_q.fcnt};
                ledsh_pkg::ADDR_STAT: begin
                    s_d.rdata = {s_q.done, (s_q.fcnt == 3'h0), s_q.refill,
                                 sclk, 1'b0, s_q.fcnt};
                end
                default:                  s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_q        <= '0;
            s_q.ctrl   <= ledsh_pkg::CTRL_RST;
            s_q.ck_div <= ledsh_pkg::CK_DIV_RST;
            s_q.wcnt   <= ledsh_pkg::WORD_CNT_RST;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata_o = s_q.rdata;
    assign dma_o.req   = (s_q.dst != ledsh_pkg::LEDSH_DMA_IDLE) &&
                         !s_q.gap;
    assign dma_o.addr  = (s_q.dst == ledsh_pkg::LEDSH_DMA_AUX) ?
                         {s_q.xptr, 1'b0} : {s_q.mptr, 1'b0};
    assign pins_o.sclk = sclk;
    // polarity inverts data lanes only; disabled output holds lanes low
    assign pins_o.lane = out_en ?
                         (s_q.lanes ^ {4{s_q.ctrl[ledsh_pkg::CTRL_POLARITY]}})
                         : 4'h0;

endmodule : ledsh_top

// ---- ledsh_pkg.sv ----
// package: register map, field layout, reset values and carrier types
package ledsh_pkg;

    // register addresses on the special function register port
    localparam logic [15:0] ADDR_CTRL     = 16'h2880;
    localparam logic [15:0] ADDR_STAT     = 16'h2881;
    localparam logic [15:0] ADDR_DATA     = 16'h2882;
    localparam logic [15:0] ADDR_CK_DIV   = 16'h2883;
    localparam logic [15:0] ADDR_MPTR_HI  = 16'h2884;
    localparam logic [15:0] ADDR_MPTR_LO  = 16'h2885;
    localparam logic [15:0] ADDR_WORD_CNT = 16'h2886;
    localparam logic [15:0] ADDR_FIFO_CN  = 16'h2887;
    localparam logic [15:0] ADDR_XPTR_HI  = 16'h2888;
    localparam logic [15:0] ADDR_XPTR_LO  = 16'h2889;

    // panel_control_reg fields
    localparam int CTRL_BIT_ORDER = 0;
    localparam int CTRL_CLR_ALL   = 1;
    localparam int CTRL_POLARITY  = 2;
    localparam int CTRL_OUT_EN    = 3;
    localparam int CTRL_DMA_EN    = 4;
    localparam int CTRL_IE_REQ    = 5;
    localparam int CTRL_MODE_LO   = 6;
    localparam int CTRL_MODE_HI   = 7;

    // status register fields
    localparam int STAT_DMA_DONE  = 7;
    localparam int STAT_EMPTY     = 6;
    localparam int STAT_REFILL    = 5;
    localparam int STAT_SCLK      = 4;

    // reset values
    localparam logic [7:0] CTRL_RST    = 8'h02;
    localparam logic [7:0] CK_DIV_RST  = 8'h10;
    localparam logic [7:0] WORD_CNT_RST = 8'h00;

    localparam logic [2:0] REFILL_LEVEL = 3'h2;
    localparam logic [7:0] CK_DIV_MIN   = 8'h02;

    // lane modes
    localparam logic [1:0] MODE_ONE   = 2'h0;
    localparam logic [1:0] MODE_TWO   = 2'h1;
    localparam logic [1:0] MODE_FOUR  = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    typedef enum logic [1:0] {
        LEDSH_DMA_IDLE,
        LEDSH_DMA_MAIN,
        LEDSH_DMA_AUX
    } ledsh_dma_st_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } ledsh_sfr_req_t;

    typedef struct packed {
        logic        req;
        logic [11:0] addr;
    } ledsh_dma_req_t;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } ledsh_dma_rsp_t;

    typedef struct packed {
        logic       sclk;
        logic [3:0] lane;
    } ledsh_pins_t;

endpackage : ledsh_pkg

// ---- ledsh_clkdiv.sv ----
// serial clock divider: makes the panel clock and a shift tick
`timescale 1ns/10ps
module ledsh_clkdiv (
    // clock, reset and enable
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    // control
    input  wire logic       run_i,
    input  wire logic [7:0] factor_i,
    // outputs
    output logic            tick_o,
    output logic            sclk_o
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       sclk;
    } ledsh_div_st_t;

    ledsh_div_st_t s_q;
    ledsh_div_st_t s_d;
    logic [7:0]    eff;
    logic [7:0]    last;
    logic [7:0]    half;

    // factors below the minimum would need a clock faster than clk_i / 2
    assign eff  = (factor_i < ledsh_pkg::CK_DIV_MIN) ?
                  ledsh_pkg::CK_DIV_MIN : factor_i;
    assign last = eff - 8'h01;
    assign half = eff >> 1;

    assign tick_o = run_i && (s_q.cnt == last);
    assign sclk_o = s_q.sclk;

    always_comb begin
        s_d = s_q;
        if (!run_i) begin
            s_d.cnt  = 8'h00;
            s_d.sclk = 1'b0;
        end else if (s_q.cnt == last) begin
            s_d.cnt  = 8'h00;
            s_d.sclk = 1'b0;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_d.cnt == half) begin
                s_d.sclk = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

endmodule : ledsh_clkdiv

// ---- ledsh_props.sv ----
// checker: port assertions for the led panel shifter
`timescale 1ns/10ps
module ledsh_chk #(
    parameter int FIFO_DEPTH = 4
) (
    // clock, reset and enable
    input wire logic                      clk_i,
    input wire logic                      resetn_i,
    input wire logic                      ce_i,
    // watched ports
    input wire ledsh_pkg::ledsh_sfr_req_t sfr_i,
    input wire logic [7:0]                sfr_rdata_o,
    input wire ledsh_pkg::ledsh_dma_req_t dma_o,
    input wire ledsh_pkg::ledsh_dma_rsp_t dma_i,
    input wire ledsh_pkg::ledsh_pins_t    pins_o
);
    logic [7:0] ctrl_q;
    logic       rd_ok;
    logic       quiet;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    assign rd_ok = sfr_i.rd && ce_i;
    // shadow of the control byte; polarity off keeps idle lanes at 0
    assign quiet = !ctrl_q[ledsh_pkg::CTRL_OUT_EN]
                && !ctrl_q[ledsh_pkg::CTRL_POLARITY];
    always_ff @(posedge clk_i) begin
        if (!resetn_i)
            ctrl_q <= ledsh_pkg::CTRL_RST;
        else if (ce_i && sfr_i.wr && sfr_i.addr == ledsh_pkg::ADDR_CTRL)
            ctrl_q <= sfr_i.wdata;
    end
    chk_port_reads_zero: assert property (
        rd_ok && sfr_i.addr == ledsh_pkg::ADDR_DATA |=> sfr_rdata_o == 8'h00)
        else $error("data port read returned nonzero");
    chk_high_nibble_zero: assert property (
        rd_ok && (sfr_i.addr == ledsh_pkg::ADDR_MPTR_HI
              || sfr_i.addr == ledsh_pkg::ADDR_XPTR_HI)
        |=> sfr_rdata_o[7:4] == 4'h0)
        else $error("pointer high byte upper bits not zero");
    chk_low_bit_zero: assert property (
        rd_ok && (sfr_i.addr == ledsh_pkg::ADDR_MPTR_LO
              || sfr_i.addr == ledsh_pkg::ADDR_XPTR_LO)
        |=> !sfr_rdata_o[0])
        else $error("pointer low byte bit 0 not zero");
    chk_fetch_addr_even: assert property (
        dma_o.req |-> !dma_o.addr[0])
        else $error("odd fetch address");
    chk_fetch_held: assert property (
        dma_o.req && !dma_i.ack |=> dma_o.req && $stable(dma_o.addr))
        else $error("fetch request dropped or moved before answer");
    chk_fetch_ends: assert property (
        dma_o.req && dma_i.ack && ce_i |=> !dma_o.req)
        else $error("fetch request still high after answer");
    chk_lanes_idle: assert property (
        quiet ##1 quiet |-> pins_o.lane == 4'h0)
        else $error("lanes active while output disabled");
    chk_clock_frozen: assert property (
        // the divider flop lags the control byte by one cycle
        quiet ##1 quiet ##1 quiet |-> $stable(pins_o.sclk))
        else $error("serial clock moving while output disabled");
    chk_rdata_held: assert property (
        !rd_ok |=> $stable(sfr_rdata_o))
        else $error("read data changed without a read");
endmodule : ledsh_chk

bind ledsh_top ledsh_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .sfr_i      (sfr_i),
    .sfr_rdata_o(sfr_rdata_o),
    .dma_o      (dma_o),
    .dma_i      (dma_i),
    .pins_o     (pins_o)
);

// ---- ledsh_xram.sv ----
// partner: buffer memory answering the shifter's word fetches
`timescale 1ns/10ps
module ledsh_xram (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    // fetch port and answer delay
    input  wire ledsh_pkg::ledsh_dma_req_t dma_i,
    input  wire logic [3:0]                lat_i,
    output ledsh_pkg::ledsh_dma_rsp_t      dma_o,
    output logic [7:0]                     fetches_o
);
    logic [3:0] wait_q;
    // image of the buffers: a fixed function of the byte address
    function automatic logic [7:0] mem(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'hc};
    endfunction : mem
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dma_o     <= '0;
            wait_q    <= '0;
            fetches_o <= '0;
        end else if (dma_i.req && !dma_o.ack && wait_q == lat_i) begin
            dma_o.ack   <= 1'b1;
            dma_o.rdata <= {mem(dma_i.addr + 12'h001), mem(dma_i.addr)};
            wait_q      <= '0;
            fetches_o   <= fetches_o + 8'h01;
        end else begin
            // no stale word between answers: data toggles every cycle
            dma_o.ack   <= 1'b0;
            dma_o.rdata <= ~dma_o.rdata;
            wait_q      <= (dma_i.req && !dma_o.ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule : ledsh_xram

// ---- ledsh_top_tb_top.sv ----
// testbench: register table, fifo port, dma streaming in every lane mode
`timescale 1ns/10ps
module ledsh_top_tb_top;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rexp;
    } ledsh_row_t;
    logic                      clk_i;
    logic                      resetn_i;
    logic                      ce;
    ledsh_pkg::ledsh_sfr_req_t sfr;
    logic [7:0]                rdata;
    ledsh_pkg::ledsh_dma_req_t dma_req;
    ledsh_pkg::ledsh_dma_rsp_t dma_rsp;
    ledsh_pkg::ledsh_pins_t    pins;
    logic [3:0]                lat;
    logic [7:0]                fetches;
    logic [7:0]                f0;
    logic [7:0]                c;
    logic [1:0]                md;
    logic                      mon_on;
    logic                      seen_fall;
    logic [3:0]                steps[$];
    ledsh_row_t                rows[7];
    int                        n;
    int                        t;
    int                        bad_count;
    int                        compares;

    ledsh_top #(.FIFO_DEPTH(4)) dut (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .ce_i       (ce),
        .sfr_i      (sfr),
        .sfr_rdata_o(rdata),
        .dma_o      (dma_req),
        .dma_i      (dma_rsp),
        .pins_o     (pins)
    );
    ledsh_xram u_xram (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .dma_i    (dma_req),
        .lat_i    (lat),
        .dma_o    (dma_rsp),
        .fetches_o(fetches)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // lanes change on the clock fall, so a step starts after the first fall
    always @(negedge pins.sclk) if (mon_on) seen_fall <= 1'b1;
    always @(posedge pins.sclk)
        if (mon_on && seen_fall) steps.push_back(pins.lane);

    function automatic logic [7:0] bytev(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'hc};
    endfunction : bytev

    function automatic logic [3:0] exp_lanes(input logic [1:0] m, input int s);
        int         nl;
        int         j;
        int         i;
        logic [7:0] b;
        logic [3:0] r;
        nl = (m == 2'h3) ? 2 : 1 << m;
        j  = (m == 2'h3) ? s / 4 : s / (8 / nl);
        i  = (m == 2'h3) ? s % 4 : s % (8 / nl);
        r  = 4'h0;
        for (int k = 0; k < 4; k++) begin
            b = bytev((m == 2'h3 && k > 1) ? 12'h200 + 12'(j)
                                           : 12'h100 + 12'(j));
            if (k < nl || m == 2'h3)
                r[k] = m[0] ? b[7 - (i * nl + k % nl)] : b[i * nl + k % nl];
        end
        return r;
    endfunction : exp_lanes

    task automatic cmp(input string w, input logic [7:0] e,
                       input logic [7:0] g, input logic [7:0] mk = 8'hff);
        compares++;
        if (((g ^ e) & mk) !== 8'h00) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", w, e, g);
        end
    endtask : cmp

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        sfr.addr  = a;
        sfr.wdata = d;
        sfr.wr    = 1'b1;
        @(negedge clk_i);
        sfr.wr = 1'b0;
    endtask : wr

    task automatic rdc(input string w, input logic [15:0] a,
                       input logic [7:0] e, input logic [7:0] mk = 8'hff);
        @(negedge clk_i);
        sfr.addr = a;
        sfr.rd   = 1'b1;
        @(negedge clk_i);
        sfr.rd = 1'b0;
        @(negedge clk_i);
        cmp(w, e, rdata, mk);
    endtask : rdc

    task automatic end_of_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic stall(input string w);
        bad_count++;
        $display("unexpected %s expected done seen timeout", w);
        end_of_test();
    endtask : stall

    initial begin
        sfr       = '0;
        resetn_i  = 1'b0;
        lat       = 4'h0;
        ce        = 1'b1;
        mon_on    = 1'b0;
        seen_fall = 1'b0;
        bad_count = 0;
        compares  = 0;
        rows[0] = '{ledsh_pkg::ADDR_CK_DIV, 8'h04, 8'h04};
        rows[1] = '{ledsh_pkg::ADDR_MPTR_HI, 8'hff, 8'h0f};
        rows[2] = '{ledsh_pkg::ADDR_MPTR_LO, 8'hff, 8'hfe};
        rows[3] = '{ledsh_pkg::ADDR_XPTR_HI, 8'hab, 8'h0b};
        rows[4] = '{ledsh_pkg::ADDR_XPTR_LO, 8'h37, 8'h36};
        rows[5] = '{ledsh_pkg::ADDR_DATA, 8'h55, 8'h00};
        rows[6] = '{16'h288a, 8'h77, 8'h00};
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        rdc("divider", ledsh_pkg::ADDR_CK_DIV, 8'h10);
        rdc("count", ledsh_pkg::ADDR_WORD_CNT, 8'h00);
        foreach (rows[r]) begin
            wr(rows[r].addr, rows[r].wdata);
            rdc("row", rows[r].addr, rows[r].rexp);
        end
        // clock enable low: a divider write is ignored
        ce = 1'b0;
        wr(ledsh_pkg::ADDR_CK_DIV, 8'h33);
        ce = 1'b1;
        rdc("frozen", ledsh_pkg::ADDR_CK_DIV, 8'h04);
        // fifo port: a full fifo drops further bytes, refill cleared by a status write stays clear
        wr(ledsh_pkg::ADDR_CTRL, 8'h00);
        repeat (5) wr(ledsh_pkg::ADDR_DATA, 8'h11);
        rdc("fifo", ledsh_pkg::ADDR_FIFO_CN, 8'h04);
        wr(ledsh_pkg::ADDR_STAT, 8'h20);
        rdc("status", ledsh_pkg::ADDR_STAT, 8'h04, 8'hef);
        wr(ledsh_pkg::ADDR_CTRL, 8'h02);
        rdc("fifo", ledsh_pkg::ADDR_FIFO_CN, 8'h00);
        for (int m = 0; m < 4; m++) begin
            md  = m[1:0];
            lat = 4'(m * 3 % 4);
            n   = (md == 2'h3) ? 16 : 32 >> md;
            c   = {md, 6'b010000} | {7'h00, md[0]};
            wr(ledsh_pkg::ADDR_CTRL, 8'h02);
            wr(ledsh_pkg::ADDR_MPTR_HI, 8'h01);
            wr(ledsh_pkg::ADDR_MPTR_LO, 8'h00);
            wr(ledsh_pkg::ADDR_XPTR_HI, 8'h02);
            wr(ledsh_pkg::ADDR_XPTR_LO, 8'h00);
            f0 = fetches;
            wr(ledsh_pkg::ADDR_CTRL, c);
            wr(ledsh_pkg::ADDR_WORD_CNT, 8'h02);
            for (t = 0; t < 500 && fetches != f0 + 8'h02; t++)
                @(negedge clk_i);
            if (t == 500)
                stall("prefill");
            @(negedge clk_i);
            steps.delete();
            seen_fall = 1'b0;
            mon_on    = 1'b1;
            wr(ledsh_pkg::ADDR_CTRL, c | 8'h08);
            for (t = 0; t < 2000 && steps.size() < n; t++)
                @(negedge clk_i);
            if (t == 2000)
                stall("lanes");
            mon_on = 1'b0;
            for (int s = 0; s < n; s++)
                cmp("lanes", {4'h0, exp_lanes(md, s)},
                    {4'h0, steps[s]});
            cmp("fetches", f0 + ((md == 2'h3) ? 8'h04 : 8'h02),
                fetches);
            rdc("count", ledsh_pkg::ADDR_WORD_CNT, 8'h00);
            rdc("main", ledsh_pkg::ADDR_MPTR_LO, 8'h04);
            rdc("aux", ledsh_pkg::ADDR_XPTR_LO,
                md[0] & md[1] ? 8'h04 : 8'h00);
            rdc("status", ledsh_pkg::ADDR_STAT, 8'he0, 8'hef);
            wr(ledsh_pkg::ADDR_STAT, 8'h80);
            rdc("status", ledsh_pkg::ADDR_STAT, 8'h60, 8'hef);
        end
        // polarity alone: idle lanes show all ones while output is enabled
        wr(ledsh_pkg::ADDR_CTRL, 8'h0c);
        cmp("polarity", 8'h0f, {4'h0, pins.lane});
        end_of_test();
    end
endmodule : ledsh_top_tb_top
